/* File: src/lsau_pkg.sv */
// Contract
// - Register offset address is base plus shifted offset.
// - Extend byte and halfword loads by signedness.
// - Word load to pointer branches with bit zero cleared.
// - No load or store alters the condition flags.
// - Unprivileged form adds small immediate, access unprivileged.
// - Unprivileged software sees ordinary immediate behaviour.
// - Pointer relative load reads instruction address plus offset.
// - Multiple transfers move words, ascending or descending.
// - Ascending mode lowest register at lowest address.
// - Ascending writeback is base plus four times count-minus-one.
// - Descending mode highest register at highest address.
// - Descending writeback is base minus four times count.
// - Stack style names map onto the two modes.
// - Multiple load with pointer branches to even address.
// - Writeback only when requested, after all transfers.
package lsau_pkg;

  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam logic [31:0] BRANCH_MASK = 32'hffff_fffe;
  localparam logic [3:0]  PTR_IDX     = 4'hf;
  localparam logic [1:0]  MEM_BYTE    = 2'h0;
  localparam logic [1:0]  MEM_HALF    = 2'h1;
  localparam logic [1:0]  MEM_WORD    = 2'h2;

  typedef enum logic [2:0] {
    SZ_WORD, SZ_UBYTE, SZ_SBYTE, SZ_UHALF, SZ_SHALF
  } lsau_size_t;

  typedef enum logic [1:0] {
    FORM_REG_OFS, FORM_UNPRIV, FORM_PC_REL, FORM_MULTI
  } lsau_form_t;

  typedef enum logic [3:0] {
    load_multiple_op, load_multi_inc_after, load_multi_full_desc,
    load_multi_dec_before, load_multi_empty_asc,
    store_multiple_op, store_multi_inc_after, store_multi_empty_asc,
    store_multi_dec_before, store_multi_full_desc
  } lsau_multi_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEL   = 3'b001,
    ST_ISSUE = 3'b011,
    ST_ACC   = 3'b010,
    ST_DONE  = 3'b110
  } lsau_state_t;

endpackage : lsau_pkg

/* File: src/lsau_ext_if.sv */
`timescale 1ns/1ps
interface lsau_ext_if;
  lsau_pkg::lsau_size_t size;
  logic [31:0]          raw;
  logic [31:0]          result;
  modport producer (output size, output raw, input result);
  modport extender (input size, input raw, output result);
endinterface : lsau_ext_if

/* File: src/lsau_extend.sv */
`timescale 1ns/1ps
module lsau_extend (
  lsau_ext_if.extender ext
);

  always_comb
  begin
    unique case (ext.size)
      lsau_pkg::SZ_UBYTE: ext.result = {24'h0, ext.raw[7:0]};
      lsau_pkg::SZ_SBYTE: ext.result = {{24{ext.raw[7]}}, ext.raw[7:0]};
      lsau_pkg::SZ_UHALF: ext.result = {16'h0, ext.raw[15:0]};
      lsau_pkg::SZ_SHALF: ext.result = {{16{ext.raw[15]}}, ext.raw[15:0]};
      default:            ext.result = ext.raw;
    endcase
  end

endmodule : lsau_extend

/* File: src/lsau_unit.sv */
`timescale 1ns/1ps
module lsau_unit (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        cmdValid,
  input  wire lsau_pkg::lsau_form_t        cmdForm,
  input  wire logic                        cmdLoad,
  input  wire lsau_pkg::lsau_size_t        cmdSize,
  input  wire logic                        cmdDual,
  input  wire lsau_pkg::lsau_multi_t       cmdMultiName,
  input  wire logic                        cmdWriteback,
  input  wire logic                        cmdCondPass,
  input  wire logic                        cmdPrivileged,
  input  wire logic [31:0]                 cmdBase,
  input  wire logic [31:0]                 cmdOffset,
  input  wire logic [1:0]                  cmdShift,
  input  wire logic [12:0]                 cmdImm,
  input  wire logic [31:0]                 cmdPc,
  input  wire logic [31:0]                 cmdStoreData,
  input  wire logic [31:0]                 cmdStoreData2,
  input  wire logic [3:0]                  cmdRt,
  input  wire logic [3:0]                  cmdRt2,
  input  wire logic [3:0]                  cmdRn,
  input  wire logic [15:0]                 cmdList,
  output logic                             cmdReady,
  output logic                             cmdDone,
  output logic [3:0]                       regRdIdx,
  input  wire logic [31:0]                 regRdData,
  output logic                             memReq,
  output logic                             memWe,
  output logic [31:0]                      memAddr,
  output logic [31:0]                      memWdata,
  output logic [1:0]                       memSize,
  output logic                             memUnpriv,
  input  wire logic                        memAck,
  input  wire logic [31:0]                 memRdata,
  output logic                             rfWe,
  output logic [3:0]                       rfIdx,
  output logic [31:0]                      rfData,
  output logic                             brValid,
  output logic [31:0]                      brTarget,
  output logic                             flagWe
);

  // Returns 1 in bit 1 when the name is a load and 1 in bit 0 for descending order.
  function automatic logic [1:0] multi_decode(input lsau_pkg::lsau_multi_t name);
    unique case (name)
      lsau_pkg::load_multiple_op, lsau_pkg::load_multi_inc_after,
      lsau_pkg::load_multi_full_desc:  multi_decode = 2'b10;
      lsau_pkg::load_multi_dec_before,
      lsau_pkg::load_multi_empty_asc:  multi_decode = 2'b11;
      lsau_pkg::store_multi_dec_before,
      lsau_pkg::store_multi_full_desc: multi_decode = 2'b01;
      default:                         multi_decode = 2'b00;
    endcase
  endfunction : multi_decode

  function automatic logic [4:0] count_regs(input logic [15:0] list);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < 16; i++)
      n = n + {4'h0, list[i]};
    return n;
  endfunction : count_regs

  // Ascending order takes the lowest pending register, descending the highest.
  function automatic logic [3:0] pick_reg(input logic [15:0] list, input logic desc);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++)
      if (desc ? list[i] : list[15 - i])
        idx = desc ? 4'(i) : 4'(15 - i);
    return idx;
  endfunction : pick_reg

  function automatic logic [1:0] mem_size(input lsau_pkg::lsau_size_t sz);
    unique case (sz)
      lsau_pkg::SZ_UBYTE, lsau_pkg::SZ_SBYTE: mem_size = lsau_pkg::MEM_BYTE;
      lsau_pkg::SZ_UHALF, lsau_pkg::SZ_SHALF: mem_size = lsau_pkg::MEM_HALF;
      default:                                mem_size = lsau_pkg::MEM_WORD;
    endcase
  endfunction : mem_size

  lsau_pkg::lsau_state_t state;
  lsau_pkg::lsau_form_t  form;
  lsau_pkg::lsau_size_t  size;
  logic                  isLoad;
  logic                  isDual;
  logic                  desc;
  logic                  wb;
  logic                  unpriv;
  logic                  second;
  logic [31:0]           base;
  logic [31:0]           addr;
  logic [31:0]           storeData;
  logic [31:0]           storeData2;
  logic [3:0]            rt;
  logic [3:0]            rt2;
  logic [3:0]            rn;
  logic [3:0]            curIdx;
  logic [15:0]           pending;
  logic [4:0]            regCount;
  logic [31:0]           next_addr;
  logic [31:0]           wbValue;
  logic [1:0]            decoded;
  logic                  lastBeat;
  logic                  cmdDoneSkip;

  lsau_ext_if ext ();
  lsau_extend u_extend (.ext(ext));

  assign ext.raw  = memRdata;
  assign ext.size = (form == lsau_pkg::FORM_MULTI) ? lsau_pkg::SZ_WORD : size;
  assign decoded  = multi_decode(cmdMultiName);

  always_comb
  begin
    unique case (cmdForm)
      lsau_pkg::FORM_REG_OFS: next_addr = cmdBase + (cmdOffset << cmdShift);
      lsau_pkg::FORM_UNPRIV:  next_addr = cmdBase + {24'h0, cmdImm[7:0]};
      lsau_pkg::FORM_PC_REL:  next_addr = cmdPc + {{19{cmdImm[12]}}, cmdImm};
      default:                next_addr = decoded[0] ? cmdBase - lsau_pkg::WORD_STEP
                                                     : cmdBase;
    endcase
  end

  assign wbValue  = desc ? base - {25'h0, regCount, 2'h0}
                         : base + {25'h0, 5'(regCount - 5'h1), 2'h0};
  assign lastBeat = (form == lsau_pkg::FORM_MULTI) ? ((pending & ~(16'h1 << curIdx)) == 16'h0)
                                                   : !(isDual && !second);

  // Sequencing of a command through its accesses and final writeback.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= lsau_pkg::ST_IDLE;
    end
    else
    begin
      unique case (state)
        lsau_pkg::ST_IDLE:  if (cmdValid)
                            state <= cmdCondPass ? lsau_pkg::ST_SEL
                                                 : lsau_pkg::ST_DONE;
        lsau_pkg::ST_SEL:   state <= lsau_pkg::ST_ISSUE;
        lsau_pkg::ST_ISSUE: state <= lsau_pkg::ST_ACC;
        lsau_pkg::ST_ACC:   if (memAck)
                            state <= lastBeat ? lsau_pkg::ST_DONE : lsau_pkg::ST_SEL;
        default:            state <= lsau_pkg::ST_IDLE;
      endcase
    end
  end

  // Capture of the command operands.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      form <= lsau_pkg::FORM_REG_OFS;
      size <= lsau_pkg::SZ_WORD;
      {isLoad, isDual, desc, wb, unpriv} <= 5'h0;
      {base, storeData, storeData2} <= 96'h0;
      {rt, rt2, rn} <= 12'h0;
      regCount <= 5'h0;
    end
    else if (state == lsau_pkg::ST_IDLE && cmdValid)
    begin
      form       <= cmdForm;
      size       <= cmdSize;
      isLoad     <= (cmdForm == lsau_pkg::FORM_MULTI) ? decoded[1] : cmdLoad;
      isDual     <= cmdDual && cmdForm == lsau_pkg::FORM_PC_REL;
      desc       <= decoded[0];
      wb         <= cmdWriteback && cmdForm == lsau_pkg::FORM_MULTI;
      unpriv     <= cmdForm == lsau_pkg::FORM_UNPRIV || !cmdPrivileged;
      base       <= cmdBase;
      storeData  <= cmdStoreData;
      storeData2 <= cmdStoreData2;
      rt         <= cmdRt;
      rt2        <= cmdRt2;
      rn         <= cmdRn;
      regCount   <= count_regs(cmdList);
    end
  end

  // Address walk and the set of registers still to move.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addr    <= 32'h0;
      pending <= 16'h0;
      second  <= 1'b0;
      curIdx  <= 4'h0;
    end
    else if (state == lsau_pkg::ST_IDLE && cmdValid)
    begin
      addr    <= next_addr;
      pending <= cmdList;
      second  <= 1'b0;
    end
    else if (state == lsau_pkg::ST_SEL)
    begin
      curIdx <= (form == lsau_pkg::FORM_MULTI) ? pick_reg(pending, desc)
                                               : (second ? rt2 : rt);
    end
    else if (state == lsau_pkg::ST_ACC && memAck)
    begin
      pending <= pending & ~(16'h1 << curIdx);
      second  <= 1'b1;
      addr    <= desc ? addr - lsau_pkg::WORD_STEP : addr + lsau_pkg::WORD_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      regRdIdx <= 4'h0;
    else if (state == lsau_pkg::ST_SEL && form == lsau_pkg::FORM_MULTI)
      regRdIdx <= pick_reg(pending, desc);
  end

  // Memory request, held until the memory system acknowledges it.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      memReq    <= 1'b0;
      memWe     <= 1'b0;
      memAddr   <= 32'h0;
      memWdata  <= 32'h0;
      memSize   <= lsau_pkg::MEM_WORD;
      memUnpriv <= 1'b0;
    end
    else if (state == lsau_pkg::ST_ISSUE)
    begin
      memReq    <= 1'b1;
      memWe     <= !isLoad;
      memAddr   <= addr;
      memWdata  <= (form == lsau_pkg::FORM_MULTI) ? regRdData : (second ? storeData2 : storeData);
      memSize   <= (form == lsau_pkg::FORM_MULTI) ? lsau_pkg::MEM_WORD : mem_size(size);
      memUnpriv <= unpriv;
    end
    else if (memAck)
    begin
      memReq <= 1'b0;
    end
  end

  // Register file and branch results; the base register only changes on writeback.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rfWe     <= 1'b0;
      rfIdx    <= 4'h0;
      rfData   <= 32'h0;
      brValid  <= 1'b0;
      brTarget <= 32'h0;
    end
    else
    begin
      rfWe    <= 1'b0;
      brValid <= 1'b0;
      if (state == lsau_pkg::ST_ACC && memAck && isLoad)
      begin
        if (curIdx == lsau_pkg::PTR_IDX)
        begin
          brValid  <= 1'b1;
          brTarget <= ext.result & lsau_pkg::BRANCH_MASK;
        end
        else
        begin
          rfWe   <= 1'b1;
          rfIdx  <= curIdx;
          rfData <= ext.result;
        end
      end
      else if (state == lsau_pkg::ST_DONE && wb && !cmdDoneSkip)
      begin
        rfWe   <= 1'b1;
        rfIdx  <= rn;
        rfData <= wbValue;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cmdDoneSkip <= 1'b0;
    else if (state == lsau_pkg::ST_IDLE && cmdValid)
      cmdDoneSkip <= !cmdCondPass;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmdReady <= 1'b0;
      cmdDone  <= 1'b0;
      flagWe   <= 1'b0;
    end
    else
    begin
      cmdReady <= state == lsau_pkg::ST_DONE || (state == lsau_pkg::ST_IDLE && !cmdValid);
      cmdDone  <= state == lsau_pkg::ST_DONE;
      flagWe   <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_flags_untouched: assert property (!flagWe)
    else $error("Flag write seen from load/store unit.");
  chk_reg_ofs_addr: assert property (state == lsau_pkg::ST_IDLE && cmdValid && cmdCondPass
      && cmdForm == lsau_pkg::FORM_REG_OFS |-> ##3 memAddr == $past(cmdBase + (cmdOffset << cmdShift), 3))
    else $error("Register offset address wrong.");
  chk_base_kept: assert property (rfWe && form != lsau_pkg::FORM_MULTI |-> state == lsau_pkg::ST_SEL
      || state == lsau_pkg::ST_DONE)
    else $error("Single transfer wrote a register outside a load result.");
  chk_sign_byte: assert property (rfWe && form != lsau_pkg::FORM_MULTI && size == lsau_pkg::SZ_SBYTE
      && state != lsau_pkg::ST_IDLE |-> rfData[31:8] == {24{rfData[7]}})
    else $error("Signed byte not sign extended.");
  chk_branch_even: assert property (brValid |-> !brTarget[0] && !rfWe)
    else $error("Branch target has bit zero set.");
  chk_unpriv_access: assert property (memReq && form == lsau_pkg::FORM_UNPRIV |-> memUnpriv)
    else $error("Unprivileged form issued privileged access.");
  chk_pcrel_addr: assert property (state == lsau_pkg::ST_IDLE && cmdValid && cmdCondPass
      && cmdForm == lsau_pkg::FORM_PC_REL |-> ##3 memAddr == $past(cmdPc + {{19{cmdImm[12]}}, cmdImm}, 3))
    else $error("PC relative address wrong.");
  chk_multi_step: assert property (state == lsau_pkg::ST_ACC && memAck && !lastBeat
      && form == lsau_pkg::FORM_MULTI |-> ##3 memAddr == $past(desc ? memAddr - 32'h4 : memAddr + 32'h4, 3))
    else $error("Multiple transfer address step wrong.");
  chk_wb_value: assert property (rfWe && state == lsau_pkg::ST_IDLE && $past(state) == lsau_pkg::ST_DONE
      |-> rfIdx == rn && rfData == wbValue)
    else $error("Writeback value wrong.");
  chk_cond_skip: assert property (state == lsau_pkg::ST_IDLE && cmdValid && !cmdCondPass
      |=> state == lsau_pkg::ST_DONE ##1 !memReq && !rfWe && !brValid)
    else $error("Skipped command had an effect.");

  cov_multi_desc_wb: cover property (state == lsau_pkg::ST_DONE && wb && desc && !cmdDoneSkip);
  cov_pc_branch: cover property (brValid);
  cov_dual_load: cover property (state == lsau_pkg::ST_DONE && isDual && second);
  cov_skip: cover property (state == lsau_pkg::ST_DONE && cmdDoneSkip);

endmodule : lsau_unit

/* File: test/lsau_mem_model.sv */
`timescale 1ns/1ps
module lsau_mem_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [2:0] waitCnt;

  // Word-aligned addresses give data with bit zero set, as a branch target needs.
  function automatic logic [31:0] memData(input logic [31:0] a);
    return {a[7:0], ~a[7:0], a[7:0] ^ 8'h5a, a[7:0] ^ 8'ha5};
  endfunction : memData

  // Read data is only valid with the acknowledge; otherwise it keeps toggling.
  always_ff @(posedge clk)
  begin
    if (srst || !memReq || memAck)
    begin
      memAck   <= 1'b0;
      waitCnt  <= 3'h0;
      memRdata <= srst ? 32'h0 : ~memRdata;
    end
    else if (waitCnt == (slow ? 3'h4 : 3'h0))
    begin
      memAck   <= 1'b1;
      memRdata <= memData(memAddr);
    end
    else
    begin
      waitCnt  <= waitCnt + 3'h1;
      memRdata <= ~memRdata;
    end
  end
endmodule : lsau_mem_model

/* File: test/load_store_addressing_unit_tb.sv */
`timescale 1ns/1ps
module load_store_addressing_unit_tb;
  typedef struct packed {
    logic [31:0] a;
    logic        we;
    logic [31:0] d;
    logic [1:0]  sz;
    logic        up;
  } lsau_acc_t;
  logic                  clk, srst, slow, cmdValid, cmdLoad, cmdDual, cmdWriteback;
  logic                  cmdCondPass, cmdPrivileged, flagSeen;
  lsau_pkg::lsau_form_t  cmdForm;
  lsau_pkg::lsau_size_t  cmdSize;
  lsau_pkg::lsau_multi_t cmdMultiName;
  logic [31:0]           cmdBase, cmdOffset, cmdPc, cmdStoreData, regRdData;
  logic [31:0]           memAddr, memWdata, memRdata, rfData, brTarget;
  logic [12:0]           cmdImm;
  logic [15:0]           cmdList;
  logic [3:0]            cmdRt, cmdRt2, cmdRn, regRdIdx, rfIdx;
  logic [1:0]            cmdShift, memSize;
  logic                  cmdReady, cmdDone, memReq, memWe, memUnpriv, memAck, rfWe, brValid;
  logic                  flagWe;
  lsau_acc_t             memQ[$];
  logic [35:0]           rfQ[$];
  logic [31:0]           brQ[$];
  int                    err_count, comparisons;

  lsau_unit i_dut (.cmdStoreData2(32'h0), .*);

  // Register file model: the value of the requested register is there at once.
  assign regRdData = {28'h1234567, regRdIdx};

  lsau_mem_model i_mem (.clk(clk), .srst(srst), .slow(slow), .memReq(memReq),
                        .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (memReq && memAck)
      memQ.push_back({memAddr, memWe, memWdata, memSize, memUnpriv});
    if (rfWe)
      rfQ.push_back({rfIdx, rfData});
    if (brValid)
      brQ.push_back(brTarget);
    if (!srst && flagWe !== 1'b0)
      flagSeen = 1'b1;
  end

  function automatic logic [31:0] ext(input lsau_pkg::lsau_size_t s, input logic [31:0] d);
    case (s)
      lsau_pkg::SZ_UBYTE: return {24'h0, d[7:0]};
      lsau_pkg::SZ_SBYTE: return {{24{d[7]}}, d[7:0]};
      lsau_pkg::SZ_UHALF: return {16'h0, d[15:0]};
      lsau_pkg::SZ_SHALF: return {{16{d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction : ext

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkAcc(input int k, input logic [31:0] a, input logic we, input logic [1:0] sz,
                        input logic up);
    chk({memQ[k].a, memQ[k].we, memQ[k].sz, memQ[k].up}, {a, we, sz, up});
  endtask : chkAcc

  // Issues the command set up by the caller and checks the traffic counts it caused.
  task automatic run(input int nMem, input int nRf, input int nBr);
    int n;
    memQ.delete();
    rfQ.delete();
    brQ.delete();
    n = 0;
    while (cmdReady !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 50, 1'b1);
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    n = 0;
    while (cmdDone !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(n < 100, 1'b1);
    chk(memQ.size(), nMem);
    chk(rfQ.size(), nRf);
    chk(brQ.size(), nBr);
    chk(flagSeen, 1'b0);
  endtask : run

  task automatic s_regofs();
    lsau_pkg::lsau_size_t sz;
    logic [31:0] a;
    cmdForm <= lsau_pkg::FORM_REG_OFS;
    cmdBase <= 32'h10000000;
    cmdRn <= 4'h5;
    for (int i = 0; i < 5; i++)
    begin
      sz = lsau_pkg::lsau_size_t'(i);
      a = 32'h10000000 + ((32'h21 * (i + 1)) << (i % 4));
      cmdLoad <= 1'b1;
      cmdSize <= sz;
      cmdOffset <= 32'h21 * (i + 1);
      cmdShift <= 2'(i % 4);
      cmdRt <= 4'h3;
      run(1, 1, 0);
      chkAcc(0, a, 1'b0, (i == 0) ? 2'h2 : (i < 3) ? 2'h0 : 2'h1, 1'b0);
      chk(rfQ[0], {4'h3, ext(sz, i_mem.memData(a))});
    end
    cmdLoad <= 1'b0;
    cmdSize <= lsau_pkg::SZ_WORD;
    cmdShift <= 2'h3;
    cmdRt <= 4'hd;
    cmdStoreData <= 32'hcafe0001;
    run(1, 0, 0);
    chkAcc(0, 32'h10000000 + (32'ha5 << 3), 1'b1, 2'h2, 1'b0);
    chk(memQ[0].d, 32'hcafe0001);
    cmdLoad <= 1'b1;
    cmdRt <= 4'hf;
    run(1, 0, 1);
    chk(brQ[0], i_mem.memData(32'h10000528) & 32'hfffffffe);
  endtask : s_regofs

  task automatic s_unpriv();
    cmdForm <= lsau_pkg::FORM_UNPRIV;
    cmdBase <= 32'h30000000;
    cmdImm <= 13'h0ff;
    cmdRt <= 4'h2;
    cmdRn <= 4'h6;
    run(1, 1, 0);
    chkAcc(0, 32'h300000ff, 1'b0, 2'h2, 1'b1);
    chk(rfQ[0], {4'h2, i_mem.memData(32'h300000ff)});
    cmdPrivileged <= 1'b0;
    cmdLoad <= 1'b0;
    cmdSize <= lsau_pkg::SZ_UBYTE;
    cmdImm <= 13'h0;
    run(1, 0, 0);
    chkAcc(0, 32'h30000000, 1'b1, 2'h0, 1'b1);
    cmdPrivileged <= 1'b1;
    cmdLoad <= 1'b1;
  endtask : s_unpriv

  task automatic s_pcrel();
    logic [12:0] imms [3] = '{13'h1001, 13'h0fff, 13'h1c04};
    logic [31:0] a;
    cmdForm <= lsau_pkg::FORM_PC_REL;
    cmdPc <= 32'h00400000;
    cmdRt <= 4'h7;
    cmdRt2 <= 4'h8;
    for (int i = 0; i < 3; i++)
    begin
      a = 32'h00400000 + {{19{imms[i][12]}}, imms[i]};
      cmdImm <= imms[i];
      cmdDual <= (i == 2);
      cmdSize <= (i == 2) ? lsau_pkg::SZ_WORD : lsau_pkg::SZ_SHALF;
      run(1 + (i == 2), 1 + (i == 2), 0);
      chkAcc(0, a, 1'b0, (i == 2) ? 2'h2 : 2'h1, 1'b0);
      chk(rfQ[0], {4'h7, (i == 2) ? i_mem.memData(a) : ext(lsau_pkg::SZ_SHALF, i_mem.memData(a))});
    end
    chkAcc(1, a + 32'h4, 1'b0, 2'h2, 1'b0);
    chk(rfQ[1], {4'h8, i_mem.memData(a + 32'h4)});
    cmdDual <= 1'b0;
  endtask : s_pcrel

  task automatic s_multi();
    logic [3:0] regs [4] = '{4'h0, 4'h2, 4'ha, 4'hb};
    logic [31:0] a;
    logic ld, db;
    int k;
    cmdForm <= lsau_pkg::FORM_MULTI;
    cmdBase <= 32'h20000100;
    cmdRn <= 4'h4;
    for (int m = 0; m < 10; m++)
    begin
      ld = m < 5;
      db = m inside {3, 4, 8, 9};
      slow <= m > 4;
      cmdMultiName <= lsau_pkg::lsau_multi_t'(m);
      cmdWriteback <= m % 2;
      cmdList <= 16'h0c05;
      run(4, (ld ? 4 : 0) + (m % 2), 0);
      for (int j = 0; j < 4; j++)
      begin
        k = db ? 3 - j : j;
        a = db ? 32'h20000100 - 4 * (j + 1) : 32'h20000100 + 4 * j;
        chkAcc(j, a, !ld, 2'h2, 1'b0);
        if (ld)
          chk(rfQ[j], {regs[k], i_mem.memData(a)});
        else
          chk(memQ[j].d, {28'h1234567, regs[k]});
      end
      if (m % 2)
        chk(rfQ[rfQ.size() - 1], {4'h4, db ? 32'h200000f0 : 32'h2000010c});
    end
    cmdWriteback <= 1'b0;
    cmdMultiName <= lsau_pkg::load_multi_inc_after;
    cmdList <= 16'h8002;
    run(2, 1, 1);
    chk(rfQ[0], {4'h1, i_mem.memData(32'h20000100)});
    chk(brQ[0], i_mem.memData(32'h20000104) & 32'hfffffffe);
    slow <= 1'b0;
  endtask : s_multi

  task automatic s_cond();
    cmdCondPass <= 1'b0;
    cmdWriteback <= 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      cmdForm <= lsau_pkg::lsau_form_t'(f);
      run(0, 0, 0);
    end
    cmdCondPass <= 1'b1;
  endtask : s_cond

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    #100000;
    err_count++;
    results();
  end

  initial
  begin
    {srst, slow, cmdValid, cmdLoad, cmdDual, cmdWriteback, flagSeen} = 7'h40;
    {cmdCondPass, cmdPrivileged} = 2'h3;
    cmdForm = lsau_pkg::FORM_REG_OFS;
    cmdSize = lsau_pkg::SZ_WORD;
    cmdMultiName = lsau_pkg::load_multi_inc_after;
    {cmdBase, cmdOffset, cmdPc, cmdStoreData} = '0;
    {cmdImm, cmdList, cmdRt, cmdRt2, cmdRn, cmdShift} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    s_regofs();
    s_unpriv();
    s_pcrel();
    s_multi();
    s_cond();
    results();
  end
endmodule : load_store_addressing_unit_tb
